/* File: hw/ctm_defines.svh */
// Register map, field positions, reset values and timing for the timer
`ifndef CTM_DEFINES_SVH
`define CTM_DEFINES_SVH

// ==========================================================
// Register byte addresses
`define CTM_ADDR_CTRL0     12'h000
`define CTM_ADDR_CTRL1     12'h004
`define CTM_ADDR_CNT_LO    12'h008
`define CTM_ADDR_CNT_HI    12'h00c
`define CTM_ADDR_CMPA_LO   12'h010
`define CTM_ADDR_CMPA_HI   12'h014
`define CTM_ADDR_FLAGS     12'h018

// ==========================================================
// Control 0 fields
`define CTM_C0_ON_BIT      3
`define CTM_C0_PERIOD_MSB  2
`define CTM_C0_PERIOD_LSB  0
`define CTM_C0_RESET       8'h00

// ==========================================================
// Control 1 fields
`define CTM_C1_MODE_MSB    7
`define CTM_C1_MODE_LSB    6
`define CTM_C1_PIN_MSB     5
`define CTM_C1_PIN_LSB     4
`define CTM_C1_INIT_BIT    3
`define CTM_C1_INV_BIT     2
`define CTM_C1_SWAP_BIT    1
`define CTM_C1_CLR_BIT     0
`define CTM_C1_RESET       8'h00

// ==========================================================
// Flag register fields
`define CTM_FL_A_BIT       0
`define CTM_FL_P_BIT       1

// ==========================================================
// Timing
`define CTM_CLK_HZ         10000000
`define CTM_P_STEP         128
`define CTM_CNT_MAX        10'h3ff

`endif

/* File: hw/ctm_pkg.sv */
// Types shared by the timer files
package ctm_pkg;
    typedef enum logic [1:0] {
        CTM_MODE_CMP   = 2'b00,
        CTM_MODE_UNDEF = 2'b01,
        CTM_MODE_PWM   = 2'b10,
        CTM_MODE_TMR   = 2'b11
    } ctm_mode_e;

    typedef enum logic [1:0] {
        CTM_PIN_HOLD = 2'b00,
        CTM_PIN_LOW  = 2'b01,
        CTM_PIN_HIGH = 2'b10,
        CTM_PIN_TOG  = 2'b11
    } ctm_pin_e;
endpackage

/* File: hw/ctm_pin_ctrl.sv */
// Output pin state logic for compare and PWM modes
`timescale 1ns/1ps
`include "ctm_defines.svh"
module ctm_pin_ctrl (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [1:0] mode,
    input  wire logic [1:0] pin_func,
    input  wire logic       init_level,
    input  wire logic       invert,
    input  wire logic       on_rise,
    input  wire logic       running,
    input  wire logic       a_match,
    input  wire logic       period_clear,
    input  wire logic       duty_match,
    output logic            pin_out
);
    logic cmp_reg;
    logic pwm_reg;
    logic pin_int;

    // ==========================================================
    // Compare mode level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_reg <= 1'b0;
        end else if (on_rise) begin
            cmp_reg <= init_level;
        end else if (running && a_match &&
                     mode == ctm_pkg::CTM_MODE_CMP) begin
            case (pin_func)
                ctm_pkg::CTM_PIN_LOW:  cmp_reg <= 1'b0;
                ctm_pkg::CTM_PIN_HIGH: cmp_reg <= 1'b1;
                ctm_pkg::CTM_PIN_TOG:  cmp_reg <= ~cmp_reg;
                default:               cmp_reg <= cmp_reg;
            endcase
        end
    end

    // ==========================================================
    // PWM phase, one while active
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_reg <= 1'b0;
        end else if (on_rise || (running && period_clear)) begin
            pwm_reg <= 1'b1;
        end else if (running && duty_match) begin
            pwm_reg <= 1'b0;
        end
    end

    // ==========================================================
    // Pin level before inversion
    always_comb begin
        pin_int = 1'b0;
        case (mode)
            ctm_pkg::CTM_MODE_CMP: pin_int = cmp_reg;
            ctm_pkg::CTM_MODE_PWM: begin
                case (pin_func)
                    2'b00:   pin_int = ~init_level;
                    2'b01:   pin_int = init_level;
                    2'b10:   pin_int = pwm_reg ? init_level : ~init_level;
                    default: pin_int = ~init_level;
                endcase
            end
            default: pin_int = 1'b0;
        endcase
    end

    // ==========================================================
    // Registered output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out <= 1'b0;
        end else if (mode == ctm_pkg::CTM_MODE_TMR) begin
            pin_out <= 1'b0;
        end else begin
            pin_out <= pin_int ^ invert;
        end
    end
endmodule

/* File: hw/ctm_timer.sv */
// Compact 10-bit timer with APB register access
`timescale 1ns/1ps
`include "ctm_defines.svh"
module ctm_timer #(
    parameter int CNT_W = 10
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        count_tick,
    output logic             timer_output_pin,
    output logic             compare_a_flag,
    output logic             compare_p_flag
);
    // Field layout and comparators are fixed at ten bits
    if (CNT_W != 10) begin : g_bad_width
        $error("ctm_timer supports only a 10-bit counter");
    end

    logic [7:0]  ctrl0_reg;
    logic [7:0]  ctrl1_reg;
    logic [9:0]  cnt_reg;
    logic [9:0]  cmpa_reg;
    logic [7:0]  buf_reg;
    logic        on_d_reg;
    logic        fa_reg;
    logic        fp_reg;
    logic [31:0] prdata_reg;

    logic        wr_en;
    logic        rd_en;
    logic        addr_ok;
    logic        on_bit;
    logic        on_rise;
    logic [2:0]  period_field;
    logic [1:0]  mode;
    logic        swap;
    logic        clr_sel;
    logic        a_match;
    logic        p_match;
    logic        overflow;
    logic        cnt_clear;
    logic        period_clear;
    logic        duty_match;
    logic        step;
    logic [9:0]  cnt_next;

    // ==========================================================
    // Helpers
    // Hit on the count before f*128, so the period is f*128 ticks
    function automatic logic p_hit(input logic [2:0] f,
                                   input logic [9:0] c);
        p_hit = (f != 3'h0) && (c[9:7] == f - 3'h1) && (c[6:0] == 7'h7f);
    endfunction

    function automatic logic [7:0] lane0(input logic [31:0] d,
                                         input logic [7:0]  old,
                                         input logic        en);
        lane0 = en ? d[7:0] : old;
    endfunction

    // ==========================================================
    // APB decode, zero wait
    assign pready  = 1'b1;
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && penable && !pwrite;
    always_comb begin
        case (paddr)
            `CTM_ADDR_CTRL0, `CTM_ADDR_CTRL1, `CTM_ADDR_CNT_LO,
            `CTM_ADDR_CNT_HI, `CTM_ADDR_CMPA_LO, `CTM_ADDR_CMPA_HI,
            `CTM_ADDR_FLAGS: addr_ok = 1'b1;
            default:         addr_ok = 1'b0;
        endcase
    end
    assign pslverr = psel && penable && !addr_ok;
    assign prdata  = prdata_reg;

    // ==========================================================
    // Field views
    assign on_bit       = ctrl0_reg[`CTM_C0_ON_BIT];
    assign period_field = ctrl0_reg[`CTM_C0_PERIOD_MSB:`CTM_C0_PERIOD_LSB];
    assign mode         = ctrl1_reg[`CTM_C1_MODE_MSB:`CTM_C1_MODE_LSB];
    assign swap         = ctrl1_reg[`CTM_C1_SWAP_BIT];
    assign clr_sel      = ctrl1_reg[`CTM_C1_CLR_BIT];
    assign on_rise      = on_bit && !on_d_reg;
    assign step         = on_bit && count_tick;

    // ==========================================================
    // Comparators
    // Period compare bits 9..7
    assign p_match  = step && p_hit(period_field, cnt_reg);
    // A match as the count would reach the value: period and duty exact
    assign a_match  = step && (cmpa_reg != 10'h000) &&
                      (cnt_reg + 10'h001 == cmpa_reg);
    assign overflow = step && (cnt_reg == `CTM_CNT_MAX);
    assign period_clear = swap ? (a_match || overflow)
                               : (period_field == 3'h0 ? overflow : p_match);
    assign duty_match   = swap ? p_match : a_match;

    always_comb begin
        if (mode == ctm_pkg::CTM_MODE_PWM) begin
            cnt_clear = period_clear;
        end else if (clr_sel) begin
            cnt_clear = a_match || overflow;
        end else begin
            cnt_clear = (period_field == 3'h0) ? overflow : p_match;
        end
    end

    // ==========================================================
    // Counter
    // Up count on tick
    assign cnt_next = cnt_clear ? 10'h000 : cnt_reg + 10'h001;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 10'h000;
        end else if (on_rise) begin
            cnt_reg <= 10'h000;
        end else if (step) begin
            cnt_reg <= cnt_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            on_d_reg <= 1'b0;
        end else begin
            on_d_reg <= on_bit;
        end
    end

    // ==========================================================
    // Match flags, set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fa_reg <= 1'b0;
            fp_reg <= 1'b0;
        end else begin
            if (a_match) begin
                fa_reg <= 1'b1;
            end else if (wr_en && paddr == `CTM_ADDR_FLAGS &&
                         pstrb[0] && pwdata[`CTM_FL_A_BIT]) begin
                fa_reg <= 1'b0;
            end
            // No P flag when A clears, outside PWM mode
            if (p_match && (!clr_sel || mode == ctm_pkg::CTM_MODE_PWM)) begin
                fp_reg <= 1'b1;
            end else if (wr_en && paddr == `CTM_ADDR_FLAGS &&
                         pstrb[0] && pwdata[`CTM_FL_P_BIT]) begin
                fp_reg <= 1'b0;
            end
        end
    end
    assign compare_a_flag = fa_reg;
    assign compare_p_flag = fp_reg;

    // ==========================================================
    // Control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl0_reg <= `CTM_C0_RESET;
            ctrl1_reg <= `CTM_C1_RESET;
        end else if (wr_en) begin
            // Mode and pin changes while running are software's risk
            if (paddr == `CTM_ADDR_CTRL0) begin
                ctrl0_reg <= lane0(pwdata, ctrl0_reg, pstrb[0]);
            end
            if (paddr == `CTM_ADDR_CTRL1) begin
                ctrl1_reg <= lane0(pwdata, ctrl1_reg, pstrb[0]);
            end
        end
    end

    // ==========================================================
    // Compare A pair and shared low-byte buffer
    // Compare A storage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmpa_reg <= 10'h000;
            buf_reg  <= 8'h00;
        end else if (wr_en && pstrb[0]) begin
            if (paddr == `CTM_ADDR_CMPA_LO) begin
                buf_reg <= pwdata[7:0];
            end else if (paddr == `CTM_ADDR_CMPA_HI) begin
                cmpa_reg <= {pwdata[1:0], buf_reg};
            end
        end else if (rd_en) begin
            if (paddr == `CTM_ADDR_CNT_HI) begin
                buf_reg <= cnt_reg[7:0];
            end else if (paddr == `CTM_ADDR_CMPA_HI) begin
                buf_reg <= cmpa_reg[7:0];
            end
        end
    end

    // ==========================================================
    // Read data, captured in the setup cycle
    // Register read view
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `CTM_ADDR_CTRL0:   prdata_reg <= {24'h000000, ctrl0_reg};
                `CTM_ADDR_CTRL1:   prdata_reg <= {24'h000000, ctrl1_reg};
                `CTM_ADDR_CNT_LO,
                `CTM_ADDR_CMPA_LO: prdata_reg <= {24'h000000, buf_reg};
                `CTM_ADDR_CNT_HI:  prdata_reg <= {30'h0, cnt_reg[9:8]};
                `CTM_ADDR_CMPA_HI: prdata_reg <= {30'h0, cmpa_reg[9:8]};
                `CTM_ADDR_FLAGS:   prdata_reg <= {30'h0, fp_reg, fa_reg};
                default:           prdata_reg <= 32'h00000000;
            endcase
        end
    end

    // ==========================================================
    // Pin logic
    ctm_pin_ctrl u_pin (
        .pclk         (pclk),
        .presetn      (presetn),
        .mode         (mode),
        .pin_func     (ctrl1_reg[`CTM_C1_PIN_MSB:`CTM_C1_PIN_LSB]),
        .init_level   (ctrl1_reg[`CTM_C1_INIT_BIT]),
        .invert       (ctrl1_reg[`CTM_C1_INV_BIT]),
        .on_rise      (on_rise),
        .running      (on_bit),
        .a_match      (a_match),
        .period_clear (period_clear),
        .duty_match   (duty_match),
        .pin_out      (timer_output_pin)
    );
endmodule

/* File: testbench/ctm_timer_assertions.sv */
// Port-level checks for the timer
`timescale 1ns/1ps
`include "ctm_defines.svh"
module ctm_timer_assertions (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        timer_output_pin,
    input wire logic        compare_a_flag,
    input wire logic        compare_p_flag
);
    // ==========================================================
    // Shadow of software state
    logic       wr;
    logic       rd;
    logic [7:0] c1;
    logic [1:0] ah;
    logic       on_q;
    logic [2:0] age;
    assign wr = psel && penable && pwrite && pstrb[0];
    assign rd = psel && penable && !pwrite;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            c1 <= 8'h00;
        end else if (wr && paddr == `CTM_ADDR_CTRL1) begin
            c1 <= pwdata[7:0];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ah <= 2'h0;
        end else if (wr && paddr == `CTM_ADDR_CMPA_HI) begin
            ah <= pwdata[1:0];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            on_q <= 1'b0;
        end else if (wr && paddr == `CTM_ADDR_CTRL0) begin
            on_q <= pwdata[3];
        end
    end
    // Settle time after any control write, pin pipeline is short
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            age <= 3'h0;
        end else if (wr && paddr <= `CTM_ADDR_CTRL1) begin
            age <= 3'h0;
        end else if (age != 3'h7) begin
            age <= age + 3'h1;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========================================================
    // Assertions
    a_hi_bits_zero: assert property (rd && (paddr == `CTM_ADDR_CNT_HI
        || paddr == `CTM_ADDR_CMPA_HI) |-> prdata[31:2] == 30'h0)
        else $error("high byte upper bits not zero");
    a_lo_byte_only: assert property (rd && (paddr == `CTM_ADDR_CNT_LO
        || paddr == `CTM_ADDR_CMPA_LO) |-> prdata[31:8] == 24'h0)
        else $error("low byte read too wide");
    a_cmpa_readback: assert property (rd && paddr == `CTM_ADDR_CMPA_HI
        |-> prdata[1:0] == ah) else $error("compare high readback");
    a_ctrl1_readback: assert property (rd && paddr == `CTM_ADDR_CTRL1
        |-> prdata[7:0] == c1) else $error("control readback");
    a_no_p_flag: assert property (age > 3'h3 && c1[0] && c1[7:6] != 2'b10
        |-> !$rose(compare_p_flag)) else $error("P flag with A clear");
    a_timer_pin_idle: assert property (age > 3'h3 && c1[7:6] == 2'b11
        |-> !timer_output_pin) else $error("pin driven in timer mode");
    a_pwm_forced_level: assert property (age > 3'h3 && on_q
        && c1[7:6] == 2'b10 && !c1[5]
        |-> timer_output_pin == ~(c1[4] ^ c1[3] ^ c1[2]))
        else $error("forced PWM level wrong");
    a_cmp_no_change: assert property (age > 3'h3 && c1[7:6] == 2'b00
        && (c1[5:4] == 2'b00 || c1[5:4] == {c1[3], !c1[3]})
        |-> $stable(timer_output_pin)) else $error("pin moved on hold");
    a_init_on_rise: assert property (c1[7:6] == 2'b00 && $rose(on_q)
        |-> ##[1:3] timer_output_pin == (c1[3] ^ c1[2]))
        else $error("pin not at initial level");
    c_cmpa_write: cover property (wr && paddr == `CTM_ADDR_CMPA_HI);
    c_p_flag: cover property ($rose(compare_p_flag));
    c_pwm_edge: cover property (c1[7:6] == 2'b10 && $rose(timer_output_pin));
endmodule

bind ctm_timer ctm_timer_assertions ctm_timer_assertions_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .timer_output_pin(timer_output_pin),
    .compare_a_flag(compare_a_flag), .compare_p_flag(compare_p_flag)
);

/* File: testbench/ctm_timer_bench.sv */
// Self-checking bench for the timer
`timescale 1ns/1ps
`include "ctm_defines.svh"
`define CHK(nm, e, g) begin \
    cmp_count++; \
    if ((g) !== (e)) begin \
        fails++; \
        $display("Error %s exp %h got %h", nm, e, g); \
    end \
end
module ctm_timer_bench;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        count_tick;
    logic        pin;
    logic        fa;
    logic        fp;
    logic [31:0] rd;
    logic        err;
    int          fails;
    int          cmp_count;
    ctm_timer #(.CNT_W(10)) ctm_timer_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .count_tick(count_tick), .timer_output_pin(pin),
        .compare_a_flag(fa), .compare_p_flag(fp)
    );
    // ==========================================================
    // Bus and stimulus helpers
    task automatic xfer(input logic [11:0] a, input logic w,
                        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Slave may stretch; pready or the bound ends the wait
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (n >= 100) fails++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e,
                       input string nm);
        xfer(a, 1'b0, 32'h0);
        `CHK(nm, e, rd)
    endtask
    task automatic ticks(input int n);
        @(posedge pclk);
        count_tick <= 1'b1;
        repeat (n) @(posedge pclk);
        count_tick <= 1'b0;
    endtask
    // Pin sampled at the edge, before that edge's updates land
    task automatic hi_count(input int n, output int c);
        c = 0;
        @(posedge pclk);
        count_tick <= 1'b1;
        repeat (300) @(posedge pclk);
        repeat (n) begin
            @(posedge pclk);
            if (pin === 1'b1) c++;
        end
        count_tick <= 1'b0;
    endtask
    task automatic restart(input logic [7:0] c1, input logic [7:0] c0);
        wr(`CTM_ADDR_CTRL0, 32'h0);
        wr(`CTM_ADDR_FLAGS, 32'h3);
        wr(`CTM_ADDR_CTRL1, {24'h0, c1});
        wr(`CTM_ADDR_CTRL0, {24'h0, c0});
    endtask
    task automatic cmpa(input logic [9:0] v);
        wr(`CTM_ADDR_CMPA_LO, {24'h0, v[7:0]});
        wr(`CTM_ADDR_CMPA_HI, {30'h0, v[9:8]});
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_reset;
        rdc(`CTM_ADDR_CTRL1, 32'h0, "ctrl1");
        rdc(`CTM_ADDR_CNT_HI, 32'h0, "cnt hi");
        rdc(`CTM_ADDR_CNT_LO, 32'h0, "cnt lo");
        rdc(`CTM_ADDR_CMPA_HI, 32'h0, "cmpa hi");
        rdc(`CTM_ADDR_CMPA_LO, 32'h0, "cmpa lo");
        xfer(12'h01c, 1'b0, 32'h0);
        `CHK("slverr", 1'b1, err)
        $display("t_reset done");
    endtask
    task automatic t_pair;
        wr(`CTM_ADDR_CMPA_LO, 32'ha5);
        rdc(`CTM_ADDR_CMPA_HI, 32'h0, "hi before");
        rdc(`CTM_ADDR_CMPA_LO, 32'h0, "lo before");
        // High read reloaded the shared buffer
        wr(`CTM_ADDR_CMPA_LO, 32'ha5);
        wr(`CTM_ADDR_CMPA_HI, 32'hffffffff);
        rdc(`CTM_ADDR_CMPA_HI, 32'h3, "hi after");
        rdc(`CTM_ADDR_CMPA_LO, 32'ha5, "lo after");
        $display("t_pair done");
    endtask
    task automatic t_count;
        restart(8'hc0, 8'h08);
        ticks(300);
        wr(`CTM_ADDR_CTRL0, 32'h0);
        ticks(5);
        `CHK("timer pin", 1'b0, pin)
        rdc(`CTM_ADDR_CNT_HI, 32'h1, "kept hi");
        rdc(`CTM_ADDR_CNT_LO, 32'h2c, "kept lo");
        wr(`CTM_ADDR_CTRL0, 32'h8);
        rdc(`CTM_ADDR_CNT_HI, 32'h0, "clr hi");
        rdc(`CTM_ADDR_CNT_LO, 32'h0, "clr lo");
        $display("t_count done");
    endtask
    task automatic t_clear;
        restart(8'hc0, 8'h09);
        ticks(133);
        wr(`CTM_ADDR_CTRL0, 32'h1);
        rdc(`CTM_ADDR_CNT_HI, 32'h0, "p hi");
        rdc(`CTM_ADDR_CNT_LO, 32'h5, "p lo");
        rdc(`CTM_ADDR_FLAGS, 32'h2, "p flags");
        `CHK("p flag outs", 2'b10, {fp, fa})
        restart(8'hc0, 8'h08);
        ticks(1027);
        wr(`CTM_ADDR_CTRL0, 32'h0);
        rdc(`CTM_ADDR_CNT_HI, 32'h0, "ovf hi");
        rdc(`CTM_ADDR_CNT_LO, 32'h3, "ovf lo");
        cmpa(10'd200);
        restart(8'hc1, 8'h09);
        ticks(205);
        wr(`CTM_ADDR_CTRL0, 32'h1);
        rdc(`CTM_ADDR_FLAGS, 32'h1, "a flags");
        `CHK("a flag outs", 2'b01, {fp, fa})
        xfer(`CTM_ADDR_CNT_HI, 1'b0, 32'h0);
        xfer(`CTM_ADDR_CNT_LO, 1'b0, 32'h0);
        `CHK("a cleared", 1'b1, rd < 32'd10)
        $display("t_clear done");
    endtask
    task automatic t_pin;
        logic [3:0] k;
        logic       e;
        cmpa(10'd10);
        for (int i = 0; i < 16; i++) begin
            k = 4'(i);
            restart({2'b00, k[1:0], k[3], k[2], 2'b01}, 8'h08);
            repeat (3) @(posedge pclk);
            #1;
            `CHK("pin init", k[3] ^ k[2], pin)
            ticks(15);
            repeat (3) @(posedge pclk);
            #1;
            case (k[1:0])
                2'b00: e = k[3];
                2'b01: e = 1'b0;
                2'b10: e = 1'b1;
                default: e = !k[3];
            endcase
            `CHK("pin act", e ^ k[2], pin)
        end
        $display("t_pin done");
    endtask
    task automatic t_pwm;
        logic [2:0] k;
        int         c;
        for (int i = 0; i < 8; i++) begin
            k = 3'(i);
            restart({3'b100, k[0], k[1], k[2], 2'b00}, 8'h09);
            ticks(20);
            #1;
            `CHK("pwm force", ~(k[0] ^ k[1] ^ k[2]), pin)
        end
        cmpa(10'd32);
        // Clear select set but ignored: period stays 128
        restart(8'had, 8'h09);
        hi_count(256, c);
        `CHK("inv duty", 192, c)
        cmpa(10'd100);
        restart(8'ha8, 8'h09);
        hi_count(256, c);
        `CHK("duty a", 200, c)
        restart(8'haa, 8'h09);
        hi_count(300, c);
        `CHK("swap full", 300, c)
        $display("t_pwm done");
    endtask
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ==========================================================
    // Clock, main sequence and watchdog
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'h1;
        count_tick = 1'b0;
        fails = 0;
        cmp_count = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_pair;
        t_count;
        t_clear;
        t_pin;
        t_pwm;
        tally_and_finish;
    end
    initial begin
        repeat (40000) @(posedge pclk);
        fails++;
        tally_and_finish;
    end
endmodule
